/* pkg/queue_cfg_pkg.sv */
// constants and types shared by the queue configuration table
package queue_cfg_pkg;
   localparam int unsigned ENTRY_SHIFT_BASE = 5;
   localparam int unsigned IMPL_BYTES = 16;
   localparam logic [1:0] OFF_CAPACITY = 2'h0;
   localparam logic [1:0] OFF_THRESHOLD = 2'h1;
   localparam logic [1:0] OFF_IDENTITY = 2'h2;
   localparam logic [1:0] OFF_MODE = 2'h3;
   localparam int unsigned SIZE_LSB = 0;
   localparam int unsigned SIZE_W = 16;
   localparam int unsigned THR_LSB = 0;
   localparam int unsigned PRIO_LSB = 4;
   localparam int unsigned PRIO_W = 4;
   localparam int unsigned PASID_LSB = 8;
   localparam int unsigned PASID_W = 20;
   localparam int unsigned PASEN_BIT = 28;
   localparam int unsigned PRIV_BIT = 29;
   localparam int unsigned MODE_BIT = 0;
   localparam int unsigned BOF_BIT = 1;
   localparam int unsigned ATS_BIT = 2;
   localparam int unsigned PRS_BIT = 3;
   localparam logic [15:0] RST_SIZE = 16'h0000;
   localparam logic [15:0] RST_THR = 16'h0000;
   localparam logic [3:0] RST_PRIO = 4'h0;
   localparam logic [19:0] RST_PASID = 20'h00000;
   localparam logic RST_BIT = 1'b0;
   localparam logic MODE_SHARED = 1'b0;
   localparam logic MODE_DEDICATED = 1'b1;
   typedef enum logic [1:0] {ACC_1 = 2'h0, ACC_2 = 2'h1, ACC_4 = 2'h2, ACC_8 = 2'h3} acc_size_t;
   typedef enum logic [2:0] {
      ERR_NONE = 3'h0,
      ERR_INACTIVE = 3'h1,
      ERR_PASID = 3'h2,
      ERR_PRIO = 3'h3,
      ERR_DEV_OFF = 3'h4
   } enable_err_t;
endpackage

/* pkg/cfg_decode_if.sv */
// address decode signals between the table and its decoder
`timescale 1ns/1ps
`default_nettype none
interface cfg_decode_if
   #(parameter int ADDR_W = 16, parameter int IDX_W = 3);
   import queue_cfg_pkg::*;
   logic [ADDR_W-1:0] addr;
   acc_size_t size;
   logic hit;
   logic aligned;
   logic impl;
   logic [IDX_W-1:0] idx;
   logic qword_sel;
   logic [7:0] byte_en;
   modport dec (input addr, input size, output hit, output aligned, output impl, output idx, output qword_sel,
      output byte_en);
   modport table_side (output addr, output size, input hit, input aligned, input impl, input idx, input qword_sel,
      input byte_en);
endinterface
`default_nettype wire

/* rtl/queue_cfg_decode.sv */
// address decoder for the per-queue configuration array
`timescale 1ns/1ps
`default_nettype none
module queue_cfg_decode
   import queue_cfg_pkg::*;
   #(
   parameter int ADDR_W = 16,
   parameter int IDX_W = 3,
   parameter int NUM_Q = 8,
   parameter int ENTRY_N = 0,
   parameter logic [ADDR_W-1:0] TABLE_BASE = 16'h0400
   )
   (
   cfg_decode_if.dec bus
   );
   localparam int SHIFT = ENTRY_N + ENTRY_SHIFT_BASE;
   localparam logic [ADDR_W:0] SPAN = (ADDR_W+1)'(NUM_Q) << SHIFT;

   function automatic logic [7:0] lane_mask(input acc_size_t sz, input logic [2:0] off);
      logic [7:0] base;
      base = (8'h01 << (1 << sz)) - 8'h01;
      if (sz == ACC_8)
         base = 8'hff;
      return base << off;
   endfunction

   function automatic logic [2:0] align_bits(input acc_size_t sz);
      return 3'((1 << sz) - 1);
   endfunction

   wire [ADDR_W:0] rel = {1'b0, bus.addr} - {1'b0, TABLE_BASE};
   wire [ADDR_W:0] in_entry = rel & ((ADDR_W+1)'(1) << SHIFT) - (ADDR_W+1)'(1);

   assign bus.hit = (bus.addr >= TABLE_BASE) && (rel < SPAN);
   assign bus.idx = IDX_W'(rel >> SHIFT);
   assign bus.aligned = (bus.addr[2:0] & align_bits(bus.size)) == 3'h0;
   assign bus.impl = in_entry < (ADDR_W+1)'(IMPL_BYTES);
   assign bus.qword_sel = in_entry[3];
   assign bus.byte_en = lane_mask(bus.size, bus.addr[2:0]);
endmodule
`default_nettype wire

/* rtl/queue_enable_check.sv */
// consistency checks applied when a queue enable is requested
`timescale 1ns/1ps
`default_nettype none
module queue_enable_check
   import queue_cfg_pkg::*;
   (
   input wire logic [15:0] size,
   input wire logic mode,
   input wire logic pasid_en,
   input wire logic [3:0] prio,
   input wire logic prio_support,
   input wire logic dev_enabled,
   output enable_err_t result
   );
   // first failing check wins, in this order
   assign result = !dev_enabled ? ERR_DEV_OFF :
      (size == 16'h0000) ? ERR_INACTIVE :
      (mode == MODE_SHARED && !pasid_en) ? ERR_PASID :
      (prio_support && prio == 4'h0) ? ERR_PRIO :
      ERR_NONE;
endmodule
`default_nettype wire

/* rtl/work_queue_config_table.sv */
// per-queue configuration register array with state-dependent field access
// Operation
// - array at table base, one entry per queue
// - entry spans two to the N plus five
// - naturally aligned 1, 2, 4, 8-byte accesses
// - writes to read-only fields are dropped
// - size writable only while device disabled
// - threshold writable with either support bit
// - priority and fault bits need disabled queue
// - no support bits means all read-only
// - zero-size queue inactive, never enabled
// - checks run on each enable request
// - bytes 1:0 hold the queue size
// - limited portal retries at threshold occupancy
// - threshold ignored for dedicated queues
// - privilege flag for dedicated queue descriptors
// - bit 28 selects PASID on translations
// - bits 27:8 hold dedicated queue PASID
// - priority used only with priority support
// - mode bit zero shared, one dedicated
`timescale 1ns/1ps
`default_nettype none
module work_queue_config_table
   import queue_cfg_pkg::*;
   #(
   parameter int ADDR_W = 16,
   parameter int NUM_Q = 8,
   parameter int ENTRY_N = 0,
   parameter logic [ADDR_W-1:0] TABLE_BASE = 16'h0400,
   parameter int IDX_W = $clog2(NUM_Q)
   )
   (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_req,
   input wire logic reg_write,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [1:0] reg_size,
   input wire logic [63:0] reg_wdata,
   output logic reg_ack,
   output logic reg_refused,
   output logic [63:0] reg_rdata,
   input wire logic cfg_support,
   input wire logic mode_support,
   input wire logic prio_support,
   input wire logic dev_enabled,
   input wire logic en_req,
   input wire logic dis_req,
   input wire logic [IDX_W-1:0] ctl_id,
   output logic ctl_done,
   output logic [2:0] ctl_err,
   output logic [NUM_Q-1:0] queue_enabled,
   input wire logic sub_req,
   input wire logic sub_limited,
   input wire logic [IDX_W-1:0] sub_id,
   input wire logic [15:0] sub_occupancy,
   output logic sub_done,
   output logic sub_retry,
   input wire logic [IDX_W-1:0] info_id,
   output logic info_active,
   output logic info_dedicated,
   output logic info_pasid_valid,
   output logic [19:0] info_pasid,
   output logic info_priv,
   output logic [3:0] info_priority,
   output logic info_bof,
   output logic info_ats_dis,
   output logic info_prs_dis
   );
   logic [15:0] size_ff [NUM_Q];
   logic [15:0] thr_ff [NUM_Q];
   logic [3:0] prio_ff [NUM_Q];
   logic [19:0] pasid_ff [NUM_Q];
   logic pasen_ff [NUM_Q];
   logic priv_ff [NUM_Q];
   logic mode_ff [NUM_Q];
   logic bof_ff [NUM_Q];
   logic ats_ff [NUM_Q];
   logic prs_ff [NUM_Q];
   logic [NUM_Q-1:0] enabled_ff;
   logic ack_ff;
   logic refused_ff;
   logic [63:0] rdata_ff;
   logic ctl_done_ff;
   logic [2:0] ctl_err_ff;
   logic sub_done_ff;
   logic sub_retry_ff;
   logic info_active_ff;
   logic info_ded_ff;
   logic info_pv_ff;
   logic [19:0] info_pasid_ff;
   logic info_priv_ff;
   logic [3:0] info_prio_ff;
   logic info_bof_ff;
   logic info_ats_ff;
   logic info_prs_ff;

   function automatic logic [63:0] expand(input logic [7:0] be);
      logic [63:0] m;
      m = 64'h0;
      for (int i = 0; i < 8; i++)
         m[i*8 +: 8] = {8{be[i]}};
      return m;
   endfunction

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? b : a;
   endfunction

   // fields come in as arguments so the packing follows every register update
   function automatic logic [31:0] ident_word(input logic [3:0] prio, input logic [19:0] pasid, input logic pasen,
      input logic priv);
      logic [31:0] w;
      w = 32'h0;
      w[PRIO_LSB +: PRIO_W] = prio;
      w[PASID_LSB +: PASID_W] = pasid;
      w[PASEN_BIT] = pasen;
      w[PRIV_BIT] = priv;
      return w;
   endfunction

   function automatic logic [31:0] mode_word(input logic mode, input logic bof, input logic ats,
      input logic prs);
      logic [31:0] w;
      w = 32'h0;
      w[MODE_BIT] = mode;
      w[BOF_BIT] = bof;
      w[ATS_BIT] = ats;
      w[PRS_BIT] = prs;
      return w;
   endfunction

   cfg_decode_if #(.ADDR_W(ADDR_W), .IDX_W(IDX_W)) dec_if ();

   assign dec_if.addr = reg_addr;
   assign dec_if.size = acc_size_t'(reg_size);

   queue_cfg_decode #(
      .ADDR_W(ADDR_W),
      .IDX_W(IDX_W),
      .NUM_Q(NUM_Q),
      .ENTRY_N(ENTRY_N),
      .TABLE_BASE(TABLE_BASE)
   ) u_decode (
      .bus(dec_if)
   );

   // register access decode
   wire [IDX_W-1:0] sel = dec_if.idx;
   wire access_ok = dec_if.hit && dec_if.aligned;
   wire mapped = access_ok && dec_if.impl;
   wire wr_fire = reg_req && reg_write && mapped;
   wire [63:0] lane_m = expand(dec_if.byte_en);
   wire sel_enabled = enabled_ff[sel];

   // reserved bits fall out as zero from the field packing
   wire [31:0] word_cap = {16'h0000, size_ff[sel]};
   wire [31:0] word_thr = {16'h0000, thr_ff[sel]};
   wire [31:0] word_ident = ident_word(prio_ff[sel], pasid_ff[sel], pasen_ff[sel], priv_ff[sel]);
   wire [31:0] word_mode = mode_word(mode_ff[sel], bof_ff[sel], ats_ff[sel], prs_ff[sel]);
   wire [63:0] old_q = dec_if.qword_sel ? {word_mode, word_ident} : {word_thr, word_cap};
   wire [63:0] merged = (old_q & ~lane_m) | (reg_wdata & lane_m);
   wire [63:0] nxt_rdata = mapped ? (old_q & lane_m) : 64'h0;

   // field access rights, mode support itself is an input and never stored
   wire size_wr = cfg_support && !dev_enabled;
   wire thr_wr = cfg_support || mode_support;
   wire ident_wr = !sel_enabled && (cfg_support || mode_support);
   wire misc_wr = !sel_enabled && cfg_support;
   wire lo_q = !dec_if.qword_sel;
   wire hi_q = dec_if.qword_sel;

   // a read-only field keeps its value, so a touched lane there is dropped
   wire [15:0] nxt_size = (lo_q && size_wr) ? merged[SIZE_LSB +: SIZE_W] : size_ff[sel];
   wire [15:0] nxt_thr = (lo_q && thr_wr) ? merged[32 + THR_LSB +: SIZE_W] : thr_ff[sel];
   wire [19:0] nxt_pasid = (hi_q && ident_wr) ? merged[PASID_LSB +: PASID_W] : pasid_ff[sel];
   wire nxt_pasen = (hi_q && ident_wr) ? merged[PASEN_BIT] : pasen_ff[sel];
   wire nxt_priv = (hi_q && ident_wr) ? merged[PRIV_BIT] : priv_ff[sel];
   wire nxt_mode = (hi_q && ident_wr) ? merged[32 + MODE_BIT] : mode_ff[sel];
   wire [3:0] nxt_prio = (hi_q && misc_wr) ? merged[PRIO_LSB +: PRIO_W] : prio_ff[sel];
   wire nxt_bof = (hi_q && misc_wr) ? merged[32 + BOF_BIT] : bof_ff[sel];
   wire nxt_ats = (hi_q && misc_wr) ? merged[32 + ATS_BIT] : ats_ff[sel];
   wire nxt_prs = (hi_q && misc_wr) ? merged[32 + PRS_BIT] : prs_ff[sel];

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int q = 0; q < NUM_Q; q++)
         begin
            size_ff[q] <= RST_SIZE;
            thr_ff[q] <= RST_THR;
            prio_ff[q] <= RST_PRIO;
            pasid_ff[q] <= RST_PASID;
            pasen_ff[q] <= RST_BIT;
            priv_ff[q] <= RST_BIT;
            mode_ff[q] <= RST_BIT;
            bof_ff[q] <= RST_BIT;
            ats_ff[q] <= RST_BIT;
            prs_ff[q] <= RST_BIT;
         end
      end
      else if (wr_fire)
      begin
         size_ff[sel] <= nxt_size;
         thr_ff[sel] <= nxt_thr;
         prio_ff[sel] <= nxt_prio;
         pasid_ff[sel] <= nxt_pasid;
         pasen_ff[sel] <= nxt_pasen;
         priv_ff[sel] <= nxt_priv;
         mode_ff[sel] <= nxt_mode;
         bof_ff[sel] <= nxt_bof;
         ats_ff[sel] <= nxt_ats;
         prs_ff[sel] <= nxt_prs;
      end
   end

   // every request answers next cycle, refused ones with zero data
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ack_ff <= 1'b0;
         refused_ff <= 1'b0;
         rdata_ff <= 64'h0;
      end
      else
      begin
         ack_ff <= reg_req;
         refused_ff <= reg_req && !access_ok;
         rdata_ff <= (reg_req && !reg_write) ? nxt_rdata : 64'h0;
      end
   end

   // queue enable and disable, checks see the values before a same-cycle write
   enable_err_t chk_result;

   queue_enable_check u_check (
      .size(size_ff[ctl_id]),
      .mode(mode_ff[ctl_id]),
      .pasid_en(pasen_ff[ctl_id]),
      .prio(prio_ff[ctl_id]),
      .prio_support(prio_support),
      .dev_enabled(dev_enabled),
      .result(chk_result)
   );

   wire do_enable = en_req && !dis_req && (chk_result == ERR_NONE);
   wire [NUM_Q-1:0] id_bit = NUM_Q'(1) << ctl_id;
   wire [NUM_Q-1:0] nxt_enabled = !dev_enabled ? '0 :
      dis_req ? (enabled_ff & ~id_bit) :
      do_enable ? (enabled_ff | id_bit) : enabled_ff;
   wire [2:0] nxt_ctl_err = (en_req && !dis_req) ? 3'(chk_result) : 3'(ERR_NONE);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         enabled_ff <= '0;
         ctl_done_ff <= 1'b0;
         ctl_err_ff <= 3'h0;
      end
      else
      begin
         enabled_ff <= nxt_enabled;
         ctl_done_ff <= en_req || dis_req;
         ctl_err_ff <= nxt_ctl_err;
      end
   end

   // limited portal admission
   wire [15:0] eff_thr = min16(thr_ff[sub_id], size_ff[sub_id]);
   wire sub_shared = mode_ff[sub_id] == MODE_SHARED;
   wire nxt_retry = sub_req && sub_limited && sub_shared && (sub_occupancy >= eff_thr);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sub_done_ff <= 1'b0;
         sub_retry_ff <= 1'b0;
      end
      else
      begin
         sub_done_ff <= sub_req;
         sub_retry_ff <= nxt_retry;
      end
   end

   // descriptor attributes; ignored fields are presented as zero
   wire info_live = size_ff[info_id] != 16'h0000;
   wire info_ded = info_live && (mode_ff[info_id] == MODE_DEDICATED);
   wire info_pv = info_ded && pasen_ff[info_id];
   wire [19:0] nxt_info_pasid = info_pv ? pasid_ff[info_id] : 20'h00000;
   wire nxt_info_priv = info_pv && priv_ff[info_id];
   wire [3:0] nxt_info_prio = (info_live && prio_support) ? prio_ff[info_id] : 4'h0;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         info_active_ff <= 1'b0;
         info_ded_ff <= 1'b0;
         info_pv_ff <= 1'b0;
         info_pasid_ff <= 20'h00000;
         info_priv_ff <= 1'b0;
         info_prio_ff <= 4'h0;
         info_bof_ff <= 1'b0;
         info_ats_ff <= 1'b0;
         info_prs_ff <= 1'b0;
      end
      else
      begin
         info_active_ff <= info_live;
         info_ded_ff <= info_ded;
         info_pv_ff <= info_pv;
         info_pasid_ff <= nxt_info_pasid;
         info_priv_ff <= nxt_info_priv;
         info_prio_ff <= nxt_info_prio;
         info_bof_ff <= info_live && bof_ff[info_id];
         info_ats_ff <= info_live && ats_ff[info_id];
         info_prs_ff <= info_live && prs_ff[info_id];
      end
   end

   assign reg_ack = ack_ff;
   assign reg_refused = refused_ff;
   assign reg_rdata = rdata_ff;
   assign ctl_done = ctl_done_ff;
   assign ctl_err = ctl_err_ff;
   assign queue_enabled = enabled_ff;
   assign sub_done = sub_done_ff;
   assign sub_retry = sub_retry_ff;
   assign info_active = info_active_ff;
   assign info_dedicated = info_ded_ff;
   assign info_pasid_valid = info_pv_ff;
   assign info_pasid = info_pasid_ff;
   assign info_priv = info_priv_ff;
   assign info_priority = info_prio_ff;
   assign info_bof = info_bof_ff;
   assign info_ats_dis = info_ats_ff;
   assign info_prs_dis = info_prs_ff;
endmodule
`default_nettype wire

/* bench/work_queue_config_table_asserts.sv */
// port-level assertion checker for the queue configuration table
`timescale 1ns/1ps
`default_nettype none
module work_queue_config_table_asserts
   #(
   parameter int ADDR_W = 16,
   parameter int NUM_Q = 8,
   parameter int ENTRY_N = 0,
   parameter logic [ADDR_W-1:0] TABLE_BASE = 16'h0400
   )
   (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_req,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [1:0] reg_size,
   input wire logic reg_ack,
   input wire logic reg_refused,
   input wire logic [63:0] reg_rdata,
   input wire logic dev_enabled,
   input wire logic en_req,
   input wire logic dis_req,
   input wire logic ctl_done,
   input wire logic [NUM_Q-1:0] queue_enabled,
   input wire logic sub_req,
   input wire logic sub_limited,
   input wire logic sub_done,
   input wire logic sub_retry
   );
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property (reg_req |=> reg_ack) else $error("no ack after request");
   AST_NO_STRAY_ACK: assert property (!reg_req |=> !reg_ack && !reg_refused)
      else $error("ack without request");
   AST_MISALIGN: assert property (reg_req && (reg_addr[2:0] & ((3'h1 << reg_size) - 3'h1)) != 3'h0
      |=> reg_refused) else $error("misaligned access not refused");
   AST_OUTSIDE: assert property (reg_req && (reg_addr < TABLE_BASE
      || reg_addr >= TABLE_BASE + (NUM_Q << (ENTRY_N + 5))) |=> reg_refused) else $error("outside access taken");
   AST_REFUSED_ZERO: assert property (reg_refused |-> reg_ack && reg_rdata == 64'h0)
      else $error("refused access returned data");
   AST_CTL_DONE: assert property (en_req || dis_req |=> ctl_done) else $error("no enable answer");
   AST_DEV_OFF: assert property (!dev_enabled |=> queue_enabled == '0) else $error("queue on with device off");
   AST_EN_CAUSE: assert property (queue_enabled != $past(queue_enabled)
      |-> $past(en_req || dis_req || !dev_enabled)) else $error("queue state changed without cause");
   AST_SUB_DONE: assert property (sub_req |=> sub_done) else $error("no submission answer");
   AST_RETRY_LIMITED: assert property (sub_req && !sub_limited |=> !sub_retry)
      else $error("retry on unlimited portal");
endmodule
bind work_queue_config_table work_queue_config_table_asserts #(.ADDR_W(ADDR_W), .NUM_Q(NUM_Q),
   .ENTRY_N(ENTRY_N), .TABLE_BASE(TABLE_BASE)) u_chk (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
   .reg_addr(reg_addr), .reg_size(reg_size), .reg_ack(reg_ack), .reg_refused(reg_refused), .reg_rdata(reg_rdata),
   .dev_enabled(dev_enabled), .en_req(en_req), .dis_req(dis_req), .ctl_done(ctl_done),
   .queue_enabled(queue_enabled), .sub_req(sub_req), .sub_limited(sub_limited), .sub_done(sub_done),
   .sub_retry(sub_retry));
`default_nettype wire

/* bench/tb_work_queue_config_table.sv */
// self-checking bench for the queue configuration table
`timescale 1ns/1ps
`default_nettype none
module tb_work_queue_config_table;
   import queue_cfg_pkg::*;
   localparam logic [15:0] BASE = 16'h0400;
   logic clk_sys = 1'b0, rst = 1'b1, reg_req = 1'b0, reg_write = 1'b0, cfg_support = 1'b0, mode_support = 1'b0;
   logic prio_support = 1'b0, dev_enabled = 1'b0, en_req = 1'b0, dis_req = 1'b0, sub_req = 1'b0, sub_limited = 1'b0;
   logic [15:0] reg_addr = 16'h0, sub_occupancy = 16'h0;
   logic [1:0] reg_size = 2'h0, ctl_id = 2'h0, sub_id = 2'h0, info_id = 2'h0;
   logic [63:0] reg_wdata = 64'h0, reg_rdata, sh [4][2];
   logic reg_ack, reg_refused, ctl_done, sub_done, sub_retry, i_act, i_ded, i_pv, i_priv, i_bof, i_ats, i_prs;
   logic [2:0] ctl_err;
   logic [3:0] queue_enabled, i_prio, qon = 4'h0;
   logic [19:0] i_pasid;
   logic [15:0] lf = 16'h002a;
   int errors = 0, tests_run = 0;
   work_queue_config_table #(.NUM_Q(4)) dut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_write(reg_write),
      .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_refused(reg_refused),
      .reg_rdata(reg_rdata), .cfg_support(cfg_support), .mode_support(mode_support), .prio_support(prio_support),
      .dev_enabled(dev_enabled), .en_req(en_req), .dis_req(dis_req), .ctl_id(ctl_id), .ctl_done(ctl_done),
      .ctl_err(ctl_err), .queue_enabled(queue_enabled), .sub_req(sub_req), .sub_limited(sub_limited),
      .sub_id(sub_id), .sub_occupancy(sub_occupancy), .sub_done(sub_done), .sub_retry(sub_retry),
      .info_id(info_id), .info_active(i_act), .info_dedicated(i_ded), .info_pasid_valid(i_pv),
      .info_pasid(i_pasid), .info_priv(i_priv), .info_priority(i_prio), .info_bof(i_bof), .info_ats_dis(i_ats),
      .info_prs_dis(i_prs));
   always #5 clk_sys = ~clk_sys;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [63:0] wmask(input logic hi, input logic qo);
      logic w = cfg_support | mode_support;
      if (!hi)
         return {16'h0, w ? 16'hffff : 16'h0, 16'h0, (cfg_support && !dev_enabled) ? 16'hffff : 16'h0};
      if (qo)
         return 64'h0;
      return {28'h0, cfg_support ? 3'h7 : 3'h0, w, 2'h0, w ? 22'h3fffff : 22'h0, cfg_support ? 4'hf : 4'h0, 4'h0};
   endfunction
   function automatic logic [63:0] lanes(input logic [1:0] sz, input logic [2:0] off);
      logic [63:0] m = '0;
      for (int b = 0; b < 8; b++)
         if (b >= off && b < off + (1 << sz))
            m[8*b +: 8] = 8'hff;
      return m;
   endfunction
   function automatic logic [2:0] exp_err(input logic [1:0] q);
      if (!dev_enabled)
         return 3'h4;
      if (sh[q][0][15:0] == 16'h0)
         return 3'h1;
      if (!sh[q][1][32] && !sh[q][1][28])
         return 3'h2;
      if (prio_support && sh[q][1][7:4] == 4'h0)
         return 3'h3;
      return 3'h0;
   endfunction
   function automatic logic [30:0] exp_info(input logic [1:0] q);
      logic act = sh[q][0][15:0] != 16'h0;
      logic ded = act && sh[q][1][32];
      logic pv = ded && sh[q][1][28];
      return {act, ded, pv, pv & sh[q][1][29], (act && prio_support) ? sh[q][1][7:4] : 4'h0, pv ? sh[q][1][27:8] : 20'h0,
         act & sh[q][1][33], act & sh[q][1][34], act & sh[q][1][35]};
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic acc(input logic wr, input logic [15:0] a, input logic [1:0] sz, input logic [63:0] d,
      output logic [63:0] rd, output logic rf);
      @(posedge clk_sys);
      reg_req <= 1'b1;
      reg_write <= wr;
      reg_addr <= a;
      reg_size <= sz;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_req <= 1'b0;
      #1;
      check(reg_ack, 1'b1);
      rd = reg_rdata;
      rf = reg_refused;
   endtask
   // shadow update waits for the write so mode inputs driven by nba have landed
   task automatic put(input logic [1:0] q, input logic hi, input logic [1:0] sz, input logic [2:0] off,
      input logic [63:0] d);
      logic [63:0] m;
      logic [63:0] rd;
      logic rf;
      acc(1'b1, BASE + {q, 1'b0, hi, 3'h0} + off, sz, d, rd, rf);
      check(rf, 1'b0);
      m = wmask(hi, qon[q]) & lanes(sz, off);
      sh[q][hi] = (sh[q][hi] & ~m) | (d & m);
      acc(1'b0, BASE + {q, 1'b0, hi, 3'h0}, 2'h3, 64'h0, rd, rf);
      check(rd, sh[q][hi]);
   endtask
   task automatic ctl(input logic dis, input logic [1:0] q);
      logic [2:0] e;
      @(posedge clk_sys);
      // expectation after the edge, once capability inputs driven by nba have landed
      e = dis ? 3'h0 : exp_err(q);
      en_req <= !dis;
      dis_req <= dis;
      ctl_id <= q;
      @(posedge clk_sys);
      en_req <= 1'b0;
      dis_req <= 1'b0;
      #1;
      check(ctl_done, 1'b1);
      check(ctl_err, e);
      qon[q] = !dis && e == 3'h0;
      check(queue_enabled, qon);
   endtask
   task automatic sub(input logic lim, input logic [1:0] q, input logic [15:0] occ);
      logic [15:0] t;
      t = sh[q][0][47:32] > sh[q][0][15:0] ? sh[q][0][15:0] : sh[q][0][47:32];
      @(posedge clk_sys);
      sub_req <= 1'b1;
      sub_limited <= lim;
      sub_id <= q;
      sub_occupancy <= occ;
      @(posedge clk_sys);
      sub_req <= 1'b0;
      #1;
      check(sub_done, 1'b1);
      check(sub_retry, lim && !sh[q][1][32] && occ >= t);
   endtask
   task automatic info(input logic [1:0] q);
      @(posedge clk_sys);
      info_id <= q;
      @(posedge clk_sys);
      #1;
      check({i_act, i_ded, i_pv, i_priv, i_prio, i_pasid, i_bof, i_ats, i_prs}, exp_info(q));
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      errors++;
      wrap_up();
   end
   initial
   begin
      logic [63:0] rd;
      logic rf;
      logic [15:0] bad_a [5] = '{16'h03fc, 16'h0480, 16'h0402, 16'h0401, 16'h0404};
      logic [1:0] bad_s [5] = '{2'h2, 2'h0, 2'h2, 2'h1, 2'h3};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         sh[i / 2][i % 2] = 64'h0;
         acc(1'b0, BASE + 16'((i / 2) * 32 + (i % 2) * 8), 2'h3, 64'h0, rd, rf);
         check(rd, 64'h0);
      end
      for (int i = 0; i < 5; i++)
      begin
         acc(1'b1, bad_a[i], bad_s[i], '1, rd, rf);
         check(rf, 1'b1);
         check(rd, 64'h0);
      end
      acc(1'b1, 16'h0410, 2'h2, '1, rd, rf);
      acc(1'b0, 16'h047c, 2'h2, 64'h0, rd, rf);
      check(rf, 1'b0);
      check(rd, 64'h0);
      repeat (80)
      begin
         lf = lfsr(lf);
         @(posedge clk_sys);
         cfg_support <= lf[0];
         mode_support <= lf[1];
         dev_enabled <= lf[2];
         put(lf[4:3], lf[5], lf[7:6], lf[10:8] & ~((3'h1 << lf[7:6]) - 3'h1), {4{lfsr(lf)}});
      end
      @(posedge clk_sys);
      cfg_support <= 1'b1;
      dev_enabled <= 1'b0;
      prio_support <= 1'b1;
      put(2'h0, 1'b0, 2'h3, 3'h0, 64'h0);
      put(2'h1, 1'b0, 2'h3, 3'h0, {32'h5, 32'h8});
      put(2'h1, 1'b1, 2'h3, 3'h0, 64'h0);
      put(2'h2, 1'b0, 2'h3, 3'h0, {32'h14, 32'h8});
      put(2'h2, 1'b1, 2'h3, 3'h0, {32'h0, 32'h1000_0000});
      put(2'h3, 1'b0, 2'h3, 3'h0, {32'h1, 32'h8});
      put(2'h3, 1'b1, 2'h3, 3'h0, {32'hb, 32'h3123_4550});
      ctl(1'b0, 2'h3);
      @(posedge clk_sys);
      dev_enabled <= 1'b1;
      for (int q = 0; q < 4; q++)
         ctl(1'b0, 2'(q));
      for (int q = 0; q < 4; q++)
         info(2'(q));
      put(2'h3, 1'b1, 2'h0, 3'h0, 64'h0);
      sub(1'b1, 2'h2, 16'h7);
      sub(1'b1, 2'h2, 16'h8);
      sub(1'b0, 2'h2, 16'h8);
      sub(1'b1, 2'h3, 16'h8);
      sub(1'b1, 2'h1, 16'h5);
      sub(1'b1, 2'h1, 16'h4);
      @(posedge clk_sys);
      prio_support <= 1'b0;
      ctl(1'b0, 2'h2);
      info(2'h3);
      ctl(1'b1, 2'h3);
      wrap_up();
   end
endmodule
`default_nettype wire
